// File: logic/glitch_filter.v
// two-flop synchroniser followed by a stability filter
// assumes an asynchronous pin input and one clock domain
`timescale 1ns/1ps
`default_nettype none
module glitch_filter #(
   parameter STABLE = 4
) (
   // clock and reset
   input  wire hclk,
   input  wire hresetn,
   // pin in, clean level out
   input  wire din,
   output reg  dout
);
   reg       s1_q;
   reg       s2_q;
   reg [3:0] cnt_q;

   // synchronise, then accept a level only once it has stood still
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q  <= 1'b1;
         s2_q  <= 1'b1;
         cnt_q <= 4'h0;
         dout  <= 1'b1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         if (s2_q == dout) begin
            cnt_q <= 4'h0;
         end else if (cnt_q == STABLE[3:0] - 4'h1) begin
            cnt_q <= 4'h0;
            dout  <= s2_q;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: logic/i2c_core.v
// two-wire master clock generator, shift path and register port
// assumes an AHB-Lite master on hclk and pulled-up open-drain lines
`timescale 1ns/1ps
`default_nettype none
`include "i2c_core_defs.vh"
module i2c_core #(
   parameter FILT = 4
) (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // serial clock line
   input  wire        scl_i,
   output wire        scl_o,
   output wire        scl_oe,
   // serial data line
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe,
   // interrupt and dma events
   output wire        irq,
   output wire        dma_rx_evt,
   output wire        dma_tx_evt
);
   // one-hot engine states
   localparam [5:0] S_IDLE  = 6'h01;
   localparam [5:0] S_START = 6'h02;
   localparam [5:0] S_LOW   = 6'h04;
   localparam [5:0] S_HIGH  = 6'h08;
   localparam [5:0] S_STOPL = 6'h10;
   localparam [5:0] S_STOPH = 6'h20;

   // software registers
   reg [7:0]     ctrl_q;
   reg [7:0]     prescale_divisor;
   reg [15:0]    low_time_divisor;
   reg [15:0]    high_time_divisor;
   reg [7:0]     transmit_holding_reg;
   reg [7:0]     receive_holding_reg;
   reg [`S_W-1:0] stat_q;
   reg [`S_W-1:0] mask_q;
   reg           go_q;
   reg           tx_full_q;
   reg           rx_full_q;
   // bus pipeline
   reg           wr_q;
   reg [7:0]     wa_q;
   // clocking
   reg [7:0]     psc_act_q;
   reg [7:0]     prescaler_reg;
   reg [16:0]    ph_cnt_q;
   // engine
   reg [5:0]     state_q;
   reg [7:0]     transmit_shift_reg;
   reg [7:0]     receive_shift_reg;
   reg [3:0]     bit_idx_q;
   reg           scl_low_q;
   reg           sda_low_q;
   reg           load_q;
   reg           rxw_q;
   reg           al_q;
   reg           done_q;
   reg [31:0]    rd_mux;
   wire          scl_f;
   wire          sda_f;

   // field views of the control register
   wire       oor  = ctrl_q[`C_OOR];
   wire       mst  = ctrl_q[`C_MST];
   wire       trx  = ctrl_q[`C_TRX];
   wire [2:0] bc   = ctrl_q[`C_BC_HI:`C_BC_LO];
   // bit count 0 means a full byte, 1..7 give short words
   wire [3:0] nbits = (bc == 3'h0) ? `FULL_WORD : {1'b0, bc};

   // address decode shared by read and write paths
   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a[7:2] == off[7:2]);
      end
   endfunction

   // noise filters on both bus inputs
   glitch_filter #(.STABLE(FILT)) u_scl_filt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .din     (scl_i),
      .dout    (scl_f)
   );
   glitch_filter #(.STABLE(FILT)) u_sda_filt (
      .hclk    (hclk),
      .hresetn (hresetn),
      .din     (sda_i),
      .dout    (sda_f)
   );

   // address phase qualifier, zero wait state slave
   wire acc    = hsel & hready & htrans[1] & (hsize == `HSIZE_WORD);
   wire rd_acc = acc & ~hwrite;
   wire rd_st  = rd_acc & hit(haddr, `A_STAT);
   wire rd_rhr = rd_acc & hit(haddr, `A_RHR);
   wire wr_ctl = wr_q & hit(wa_q, `A_CTRL);
   wire wr_thr = wr_q & hit(wa_q, `A_THR);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // read data selection, unmapped words read zero
   always @* begin
      rd_mux = 32'h0000_0000;
      if (hit(haddr, `A_CTRL)) begin
         rd_mux = {24'h000000, ctrl_q[7:4], go_q, ctrl_q[2:0]};
      end else if (hit(haddr, `A_PSC)) begin
         rd_mux = {24'h000000, prescale_divisor};
      end else if (hit(haddr, `A_LOWD)) begin
         rd_mux = {16'h0000, low_time_divisor};
      end else if (hit(haddr, `A_HIGHD)) begin
         rd_mux = {16'h0000, high_time_divisor};
      end else if (hit(haddr, `A_THR)) begin
         rd_mux = {24'h000000, transmit_holding_reg};
      end else if (hit(haddr, `A_RHR)) begin
         rd_mux = {24'h000000, receive_holding_reg};
      end else if (hit(haddr, `A_STAT)) begin
         rd_mux = {28'h0000000, stat_q};
      end else if (hit(haddr, `A_MASK)) begin
         rd_mux = {28'h0000000, mask_q};
      end
   end

   // bus pipeline and register writes in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q                 <= 1'b0;
         wa_q                 <= 8'h00;
         hrdata               <= 32'h0000_0000;
         ctrl_q               <= 8'h00;
         prescale_divisor     <= 8'h00;
         psc_act_q            <= 8'h00;
         low_time_divisor     <= 16'h0000;
         high_time_divisor    <= 16'h0000;
         transmit_holding_reg <= 8'h00;
         mask_q               <= {`S_W{1'b0}};
      end else begin
         wr_q <= acc & hwrite;
         if (acc) begin
            wa_q <= haddr;
         end
         if (rd_acc) begin
            hrdata <= rd_mux;
         end
         if (wr_ctl) begin
            ctrl_q <= {hwdata[7:4], 1'b0, hwdata[2:0]};
            // divisor is copied into the running prescaler only on the rising edge
            if (hwdata[`C_OOR] & ~oor) begin
               psc_act_q <= prescale_divisor;
            end
         end
         if (wr_q & hit(wa_q, `A_PSC)) begin
            prescale_divisor <= hwdata[7:0];
         end
         if (wr_q & hit(wa_q, `A_LOWD)) begin
            low_time_divisor <= hwdata[15:0];
         end
         if (wr_q & hit(wa_q, `A_HIGHD)) begin
            high_time_divisor <= hwdata[15:0];
         end
         if (wr_thr) begin
            transmit_holding_reg <= hwdata[7:0];
         end
         if (wr_q & hit(wa_q, `A_MASK)) begin
            mask_q <= hwdata[`S_W-1:0];
         end
      end
   end

   // sticky status, go request and holding flags; a set beats a clear
   wire [`S_W-1:0] ev = {done_q, al_q, rxw_q, load_q};
   wire            start_ok;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q    <= {`S_W{1'b0}};
         go_q      <= 1'b0;
         tx_full_q <= 1'b0;
         rx_full_q <= 1'b0;
      end else begin
         stat_q    <= (stat_q & ~{`S_W{rd_st}}) | ev;
         // a go written together with out-of-reset must not be lost
         go_q      <= ((go_q & ~start_ok) | (wr_ctl & hwdata[`C_GO])) &
                      (wr_ctl ? hwdata[`C_OOR] : oor);
         tx_full_q <= (tx_full_q & ~load_q) | wr_thr;
         rx_full_q <= (rx_full_q & ~rd_rhr) | rxw_q;
      end
   end

   // interrupt and dma pacing levels
   assign irq        = |(stat_q & mask_q);
   assign dma_rx_evt = rx_full_q;
   assign dma_tx_evt = oor & trx & ~tx_full_q;

   // prescaler: module clock tick every divisor+1 input clocks, idle in reset
   wire mod_tick = oor & (prescaler_reg == psc_act_q);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prescaler_reg <= 8'h00;
      end else if (!oor | mod_tick) begin
         prescaler_reg <= 8'h00;
      end else begin
         prescaler_reg <= prescaler_reg + 8'h01;
      end
   end

   // phase length in module clock periods for the current state
   wire        high_ph = state_q[1] | state_q[3] | state_q[5];
   wire [16:0] ph_len  = high_ph ? ({1'b0, high_time_divisor} + `DIV_EXTRA)
                                 : ({1'b0, low_time_divisor} + `DIV_EXTRA);
   // high phases count only once the line is really high
   wire        ph_run  = mod_tick & (~high_ph | scl_f);
   wire        ph_end  = ph_run & (ph_cnt_q == ph_len - 17'h00001);
   wire        ph_one  = ph_run & (ph_cnt_q == `PH_FIRST);
   wire        bus_free = scl_f & sda_f;
   wire        ack_bit  = (bit_idx_q == nbits);
   assign start_ok = state_q[0] & go_q & mst & bus_free &
                     (tx_full_q | ~trx);

   // divider counter, restarts each phase and rests in reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_cnt_q <= 17'h00000;
      end else if (!oor | ph_end | state_q[0]) begin
         ph_cnt_q <= 17'h00000;
      end else if (ph_run) begin
         ph_cnt_q <= ph_cnt_q + 17'h00001;
      end
   end

   // transfer engine: start, data bits, ack bit, stop
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q             <= S_IDLE;
         transmit_shift_reg  <= 8'h00;
         receive_shift_reg   <= 8'h00;
         receive_holding_reg <= 8'h00;
         bit_idx_q           <= 4'h0;
         scl_low_q           <= 1'b0;
         sda_low_q           <= 1'b0;
         load_q              <= 1'b0;
         rxw_q               <= 1'b0;
         al_q                <= 1'b0;
         done_q              <= 1'b0;
      end else begin
         load_q <= 1'b0;
         rxw_q  <= 1'b0;
         al_q   <= 1'b0;
         done_q <= 1'b0;
         if (!oor | !mst) begin
            state_q   <= S_IDLE;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  if (start_ok) begin
                     // start condition: data low while clock high
                     state_q   <= S_START;
                     sda_low_q <= 1'b1;
                     bit_idx_q <= 4'h0;
                     receive_shift_reg <= 8'h00;
                     if (trx) begin
                        // left-align short words so the msb leaves first
                        transmit_shift_reg <= transmit_holding_reg << (`FULL_WORD - nbits);
                        load_q <= 1'b1;
                     end
                  end
               end
               S_START: begin
                  if (ph_end) begin
                     state_q   <= S_LOW;
                     scl_low_q <= 1'b1;
                  end
               end
               S_LOW: begin
                  // change data only after the clock is low
                  if (ph_one) begin
                     if (ack_bit) begin
                        sda_low_q <= ~trx;
                     end else begin
                        sda_low_q <= trx & ~transmit_shift_reg[7];
                     end
                  end
                  if (ph_end) begin
                     state_q   <= S_HIGH;
                     scl_low_q <= 1'b0;
                  end
               end
               S_HIGH: begin
                  if (ph_end) begin
                     if (!ack_bit & trx & ~sda_low_q & ~sda_f) begin
                        // another master pulled data low: back off
                        state_q   <= S_IDLE;
                        sda_low_q <= 1'b0;
                        al_q      <= 1'b1;
                     end else if (!ack_bit) begin
                        state_q   <= S_LOW;
                        scl_low_q <= 1'b1;
                        bit_idx_q <= bit_idx_q + 4'h1;
                        transmit_shift_reg <= transmit_shift_reg << 1;
                        receive_shift_reg  <= {receive_shift_reg[6:0], sda_f};
                     end else begin
                        state_q   <= S_STOPL;
                        scl_low_q <= 1'b1;
                        if (!trx) begin
                           receive_holding_reg <= receive_shift_reg;
                           rxw_q <= 1'b1;
                        end
                     end
                  end
               end
               S_STOPL: begin
                  if (ph_one) begin
                     sda_low_q <= 1'b1;
                  end
                  if (ph_end) begin
                     state_q   <= S_STOPH;
                     scl_low_q <= 1'b0;
                  end
               end
               S_STOPH: begin
                  // releasing data while clock is high makes the stop
                  if (ph_end) begin
                     state_q   <= S_IDLE;
                     sda_low_q <= 1'b0;
                     done_q    <= 1'b1;
                  end
               end
               default: begin
                  state_q   <= S_IDLE;
                  scl_low_q <= 1'b0;
                  sda_low_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // open-drain pins: drive low or release
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = scl_low_q & mst;
   assign sda_oe = sda_low_q;
endmodule
`default_nettype wire

// File: logic/i2c_core_defs.vh
// constants for the two-wire clock generator and shift path core
// assumes a 32-bit AHB-Lite slave port with word registers
`ifndef I2C_CORE_DEFS_VH
`define I2C_CORE_DEFS_VH
// register byte offsets
`define A_CTRL   8'h00
`define A_PSC    8'h04
`define A_LOWD   8'h08
`define A_HIGHD  8'h0C
`define A_THR    8'h10
`define A_RHR    8'h14
`define A_STAT   8'h18
`define A_MASK   8'h1C
// control fields
`define C_OOR    0
`define C_MST    1
`define C_TRX    2
`define C_GO     3
`define C_BC_LO  4
`define C_BC_HI  6
// status and mask fields
`define S_TXE    0
`define S_RXF    1
`define S_AL     2
`define S_DONE   3
`define S_W      4
// misc
`define HSIZE_WORD 3'h2
`define DIV_EXTRA  17'h00006
`define FULL_WORD  4'h8
`define PH_FIRST   17'h00000
`endif

// File: tb/bus_partner.sv
// far-side device on the two lines: acking slave, slave transmitter
// or rival master; assumes wired-and lines with pull-ups, sampled on hclk
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
   // clock
   input  wire logic       hclk,
   // line levels
   input  wire logic       scl_w,
   input  wire logic       sda_w,
   // pulls, high pulls the line low
   output var  logic       scl_pull,
   output var  logic       sda_pull,
   // behaviour: 0 ack, 1 transmit, 2 rival on first bit
   input  wire logic       en,
   input  wire logic [1:0] mode,
   input  wire logic [7:0] data,
   input  wire logic [3:0] n,
   input  wire logic [7:0] stretch
);
   logic       scl_d = 1'b1;
   logic       sda_d = 1'b1;
   logic [4:0] k = 5'h1F;
   logic [7:0] hold = 8'h00;
   wire  [4:0] j = k + 5'h1;
   // lines released at time zero
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // count clock falls after start and pull the lines per mode
   always @(posedge hclk) begin
      scl_d <= scl_w;
      sda_d <= sda_w;
      if (!en) begin
         k <= 5'h1F;
         hold <= 8'h00;
         scl_pull <= 1'b0;
         sda_pull <= 1'b0;
      end else if (scl_w && sda_d && !sda_w) begin
         k <= 5'h1F;
      end else if (scl_d && !scl_w) begin
         k <= j;
         hold <= stretch;
         scl_pull <= stretch != 8'h00;
         case (mode)
            2'h1: sda_pull <= j < n && !data[3'(n - 5'h1 - j)];
            2'h2: sda_pull <= j == 5'h0;
            default: sda_pull <= j == {1'b0, n};
         endcase
      end else if (hold != 8'h00) begin
         hold <= hold - 8'h01;
         scl_pull <= hold != 8'h01;
      end
   end
endmodule
`default_nettype wire

// File: tb/i2c_core_monitor.sv
// checker of the core's bus answers and serial clock timing
// assumes the ports of i2c_core, bound below, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "i2c_core_defs.vh"
module i2c_core_monitor (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // register bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // lines and events
   input wire logic        scl_o,
   input wire logic        scl_oe,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   input wire logic        irq,
   input wire logic        dma_tx_evt
);
   logic        wp_q;
   logic [7:0]  wa_q;
   logic [6:0]  ctrl_q;
   logic [7:0]  psc_q;
   logic [7:0]  pact_q;
   logic [7:0]  mask_q;
   logic [15:0] lowd_q;
   logic [15:0] highd_q;
   logic [31:0] lcnt_q;
   logic [31:0] hcnt_q;
   wire  [31:0] lexp = (lowd_q + 32'h6) * (pact_q + 32'h1);
   wire  [31:0] hexp = (highd_q + 32'h6) * (pact_q + 32'h1);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // shadow of register writes; active divisor taken as module leaves reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= 1'b0;
         wa_q <= 8'h00;
         ctrl_q <= 7'h00;
         psc_q <= 8'h00;
         pact_q <= 8'h00;
         mask_q <= 8'h00;
         lowd_q <= 16'h0000;
         highd_q <= 16'h0000;
      end else begin
         wp_q <= hsel && hready && htrans[1] && hwrite && hsize == `HSIZE_WORD;
         wa_q <= haddr;
         if (wp_q) begin
            case (wa_q)
               `A_CTRL: begin
                  ctrl_q <= hwdata[6:0];
                  if (hwdata[0] && !ctrl_q[0]) pact_q <= psc_q;
               end
               `A_PSC: psc_q <= hwdata[7:0];
               `A_LOWD: lowd_q <= hwdata[15:0];
               `A_HIGHD: highd_q <= hwdata[15:0];
               `A_MASK: mask_q <= hwdata[7:0];
               default: ;
            endcase
         end
      end
   end
   // run lengths of the driven-low and the released clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lcnt_q <= 32'h0;
         hcnt_q <= 32'h0;
      end else begin
         lcnt_q <= scl_oe ? lcnt_q + 32'h1 : 32'h0;
         hcnt_q <= scl_oe ? 32'h0 : hcnt_q + 32'h1;
      end
   end
   // start: data pulled while clock released, held before first low
   sequence s_start;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence s_start_hold;
      (sda_oe && !scl_oe) [*6];
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   a_lines_open_drain: assert property (!scl_o && !sda_o)
      else $error("line driven high");
   a_scl_needs_master: assert property (scl_oe |-> ctrl_q[1])
      else $error("clock pulled outside master mode");
   a_idle_in_reset: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> !scl_oe && !sda_oe)
      else $error("lines pulled in module reset");
   a_low_phase_len: assert property ($fell(scl_oe) && ctrl_q[0] && ctrl_q[1] |-> lcnt_q == lexp)
      else $error("clock low time wrong");
   a_high_phase_min: assert property ($rose(scl_oe) |-> hcnt_q + pact_q >= hexp)
      else $error("clock high time short");
   a_start_hold: assert property (s_start |-> s_start_hold)
      else $error("start condition too short");
   a_tx_evt_cond: assert property (dma_tx_evt |-> ctrl_q[0] && ctrl_q[2])
      else $error("transmit event outside transmit mode");
   a_irq_masked: assert property (mask_q == 8'h00 |-> !irq)
      else $error("interrupt with all masked");
endmodule
bind i2c_core i2c_core_monitor u_mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq), .dma_tx_evt(dma_tx_evt)
);
`default_nettype wire

// File: tb/test_i2c_clock_gen_and_shift_path.sv
// bench: bus master tasks, a wire sampler and the far-side model
// assumes i2c_core with its checker bound and bus_partner on the lines
`timescale 1ns/1ps
`default_nettype none
`include "i2c_core_defs.vh"
module test_i2c_clock_gen_and_shift_path;
   logic        hclk = 1'b0;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rv;
   logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe;
   logic        irq, dma_rx_evt, dma_tx_evt, scl_pull, sda_pull;
   logic        p_en;
   logic [1:0]  p_mode;
   logic [7:0]  p_data;
   logic [3:0]  p_n;
   logic [7:0]  p_hold;
   logic        scl_d = 1'b1;
   logic        sda_d = 1'b1;
   logic [4:0]  nb_q = 5'h0;
   logic [15:0] bits_q = 16'h0;
   int          n_mismatch = 0;
   int          comparisons = 0;
   wire         scl_w = ~(scl_oe | scl_pull);
   wire         sda_w = ~(sda_oe | sda_pull);
   i2c_core #(.FILT(4)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .irq(irq), .dma_rx_evt(dma_rx_evt), .dma_tx_evt(dma_tx_evt)
   );
   bus_partner PART (
      .hclk(hclk), .scl_w(scl_w), .sda_w(sda_w), .scl_pull(scl_pull),
      .sda_pull(sda_pull), .en(p_en), .mode(p_mode), .data(p_data), .n(p_n),
      .stretch(p_hold)
   );
   // 200 MHz clock
   initial forever #2.5 hclk = ~hclk;
   // sampler: bit on each clock rise, cleared by a start condition
   always @(posedge hclk) begin
      scl_d <= scl_w;
      sda_d <= sda_w;
      if (scl_w && scl_d && sda_d && !sda_w) begin
         nb_q <= 5'h0;
         bits_q <= 16'h0;
      end else if (scl_w && !scl_d) begin
         nb_q <= nb_q + 5'h1;
         bits_q <= {bits_q[14:0], sda_w};
      end
   end
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one single transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic settle;
      @(negedge hclk);
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge hclk);
      chk(irq, 1'b1);
   endtask
   // watchdog
   initial begin
      #100us;
      n_mismatch++;
      print_verdict;
   end
   initial begin
      hresetn <= 1'b0;
      hsel <= 1'b1;
      haddr <= 8'h00;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize <= `HSIZE_WORD;
      hwdata <= 32'h0;
      p_en <= 1'b0;
      p_mode <= 2'h0;
      p_data <= 8'h00;
      p_n <= 4'h8;
      p_hold <= 8'h00;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped word last
      for (int a = 0; a < 36; a += 4) rd_chk(a[7:0], 32'h0);
      wr(`A_PSC, 32'h1);
      wr(`A_HIGHD, 32'h3);
      rd_chk(`A_PSC, 32'h1);
      rd_chk(`A_HIGHD, 32'h3);
      // transmit a byte to an acking slave
      p_en <= 1'b1;
      wr(`A_THR, 32'hA5);
      wr(`A_MASK, 32'h8);
      wr(`A_CTRL, 32'hF);
      wait_irq;
      chk(dma_tx_evt, 1'b1);
      rd_chk(`A_STAT, 32'h9);
      settle;
      chk(irq, 1'b0);
      chk({nb_q, bits_q[9:0]}, {5'hA, 10'h294});
      // five-bit receive with clock stretching, divisor write ignored
      p_en <= 1'b0;
      wr(`A_PSC, 32'h7);
      p_mode <= 2'h1;
      p_data <= 8'h15;
      p_n <= 4'h5;
      p_hold <= 8'h14;
      p_en <= 1'b1;
      wr(`A_CTRL, 32'h5B);
      wait_irq;
      chk(dma_rx_evt, 1'b1);
      rd_chk(`A_STAT, 32'hA);
      rd_chk(`A_RHR, 32'h15);
      settle;
      chk(dma_rx_evt, 1'b0);
      chk({nb_q, bits_q[6:0]}, {5'h7, 7'h54});
      // rival master pulls data low on the first bit
      p_en <= 1'b0;
      p_mode <= 2'h2;
      p_hold <= 8'h00;
      wr(`A_MASK, 32'h4);
      p_en <= 1'b1;
      wr(`A_THR, 32'h80);
      wr(`A_CTRL, 32'hF);
      wait_irq;
      settle;
      chk({scl_oe, sda_oe}, 2'h0);
      p_en <= 1'b0;
      bus(1'b0, `A_STAT, 32'h0);
      chk(rv & 32'h4, 32'h4);
      // module reset, new divisor, masked completion then unmask
      wr(`A_CTRL, 32'h0);
      settle;
      chk({scl_oe, sda_oe}, 2'h0);
      wr(`A_PSC, 32'h10);
      wr(`A_MASK, 32'h0);
      p_mode <= 2'h0;
      p_n <= 4'h8;
      p_en <= 1'b1;
      wr(`A_THR, 32'h3C);
      wr(`A_CTRL, 32'hF);
      for (int i = 0; i < 4000 && nb_q !== 5'hA; i++) @(posedge hclk);
      repeat (200) @(posedge hclk);
      chk(irq, 1'b0);
      wr(`A_MASK, 32'h8);
      settle;
      chk(irq, 1'b1);
      rd_chk(`A_STAT, 32'h9);
      chk({nb_q, bits_q[9:0]}, {5'hA, 10'h0F0});
      settle;
      chk(irq, 1'b0);
      print_verdict;
   end
endmodule
`default_nettype wire
